/* rtl/qqm_consts.vh */
// constants for the four-queue mux/demux buffer
`ifndef QQM_CONSTS_VH
`define QQM_CONSTS_VH

`define QQM_AW 13
`define QQM_CW 14
`define QQM_DEPTH 14'h2000
`define QQM_DW 40
`define QQM_PINW 73

`define QQM_MODE_MUX 2'h0
`define QQM_MODE_DEMUX 2'h1
`define QQM_MODE_BCAST 2'h2

`define QQM_W_X10 2'h0
`define QQM_W_X20 2'h1
`define QQM_W_X40 2'h2
`define QQM_LAST_X10 2'h3
`define QQM_LAST_X20 2'h1
`define QQM_LAST_X40 2'h0
`define QQM_MASK_X10 40'h00000003ff
`define QQM_MASK_X20 40'h00000fffff
`define QQM_MASK_X40 40'hffffffffff
`define QQM_PORT0 4'h1

`define QQM_REG_CFG 8'h00
`define QQM_REG_STAT 8'h04
`define QQM_REG_OFS0 8'h08
`define QQM_REG_OFS3 8'h14

`define QQM_CFG_RST 9'h000
`define QQM_CFG_MODE 1:0
`define QQM_CFG_WDDR 2
`define QQM_CFG_RDDR 3
`define QQM_CFG_WW 5:4
`define QQM_CFG_RW 7:6
`define QQM_CFG_FIRST_WORD_FALL_THROUGH_MODE 8
`define QQM_CFG_BITS 8:0

`define QQM_OFS_AE 13:0
`define QQM_OFS_AF 29:16
`define QQM_AE_RST 14'h0010
`define QQM_AF_RST 14'h0010

`endif

/* rtl/qqm_mem.v */
// one queue's storage: simple dual-port memory with registered read data
`timescale 1ns/1ps
`include "qqm_consts.vh"

module qqm_mem (
    input wire clk,
    input wire we,
    input wire [`QQM_AW-1:0] waddr,
    input wire [`QQM_DW-1:0] wdata,
    input wire re,
    input wire [`QQM_AW-1:0] raddr,
    output reg [`QQM_DW-1:0] rdata
);
    reg [`QQM_DW-1:0] mem [0:(1<<`QQM_AW)-1];

    // no reset: storage content is don't-care until written
    always @(posedge clk)
    begin
        if (we)
        begin
            mem[waddr] <= wdata;
        end
        if (re)
        begin
            rdata <= mem[raddr];
        end
    end
endmodule // qqm_mem

/* rtl/qqm_top.v */
// four-queue buffer with mux, demux and broadcast write modes behind an apb slave
// How it works
// - mux mode: four independent 10-bit write ports
// - mux read port reads only selected queue
// - mux writes x10, read x10/x20/x40
// - demux write port fills selected queue only
// - demux: four independent 10-bit read ports
// - broadcast writes every word into all queues
// - broadcast blocked if any full or resetting
// - sdr or ddr chosen per side
// - ddr edge words pack into wide word
// - all port clocks asynchronous, crossed safely
// - standard or first-word-fall-through timing mode
// - four live flags per queue
// - mux composite empty and demux composite full follow selected queue
// - echo clock and enable per read port
// - configuration latched at master reset
// - partial reset clears one queue's pointers
// - partial reset keeps offsets and configuration
// - flag offsets programmable per queue
// - chip selects qualify every port access
// - all queues share one fixed depth
// - mux input lanes map ten bits per queue
// - broadcast composite full tracks any queue
// - echo enable marks freshly placed word
`timescale 1ns/1ps
`include "qqm_consts.vh"

module qqm_top (
    input wire REF_CLK,
    input wire RST,
    input wire [7:0] PADDR,
    input wire PSEL,
    input wire PENABLE,
    input wire PWRITE,
    input wire [31:0] PWDATA,
    output reg [31:0] PRDATA,
    output reg PREADY,
    output reg PSLVERR,
    input wire [3:0] WRITE_CLK,
    input wire [3:0] WRITE_EN_N,
    input wire [3:0] WRITE_CHIP_SELECT_N,
    input wire [`QQM_DW-1:0] DATA_IN,
    input wire [1:0] WRITE_QSEL,
    input wire [3:0] READ_CLK,
    input wire [3:0] READ_EN_N,
    input wire [3:0] READ_CHIP_SELECT_N,
    input wire [1:0] READ_QSEL,
    input wire [3:0] PARTIAL_RESET,
    input wire MASTER_RESET,
    output reg [`QQM_DW-1:0] DATA_OUT,
    output reg [3:0] ECHO_READ_CLOCK,
    output reg [3:0] ECHO_READ_ENABLE,
    output reg [3:0] QUEUE_EMPTY_FLAG,
    output reg [3:0] QUEUE_FULL_FLAG,
    output reg [3:0] ALMOST_EMPTY,
    output reg [3:0] ALMOST_FULL,
    output reg COMPOSITE_EMPTY_READY_FLAG,
    output reg COMPOSITE_FULL_READY_FLAG
);
    function [1:0] last_idx;
        input [1:0] w;
        begin
            last_idx = (w == `QQM_W_X20) ? `QQM_LAST_X20 : (w == `QQM_W_X40) ? `QQM_LAST_X40 : `QQM_LAST_X10;
        end
    endfunction

    function [`QQM_DW-1:0] unit_mask;
        input [1:0] w;
        begin
            unit_mask = (w == `QQM_W_X20) ? `QQM_MASK_X20 : (w == `QQM_W_X40) ? `QQM_MASK_X40 : `QQM_MASK_X10;
        end
    endfunction

    // bit offset of unit idx: idx*10 for x10, idx*20 for x20
    function [5:0] shamt;
        input [1:0] idx;
        input [1:0] w;
        reg [5:0] t;
        begin
            t = {1'b0, idx, 3'b000} + {3'b000, idx, 1'b0};
            shamt = (w == `QQM_W_X20) ? {t[4:0], 1'b0} : t;
        end
    endfunction

    // pin synchroniser; s1 feeds s2 only, edges come from s2 against its registered copy wclk_d/rclk_d
    reg [`QQM_PINW-1:0] s1;
    reg [`QQM_PINW-1:0] s2;
    reg [3:0] wclk_d;
    reg [3:0] rclk_d;
    wire [3:0] wclk_s, wen_n, wcs_n, rclk_s, ren_n, rcs_n, prs;
    wire [`QQM_DW-1:0] din;
    wire [1:0] wsel, rsel;
    wire mrs;
    assign {mrs, prs, rsel, rcs_n, ren_n, rclk_s, wsel, din, wcs_n, wen_n, wclk_s} = s2;

    always @(posedge REF_CLK or posedge RST)
    begin
        if (RST)
        begin
            s1 <= {`QQM_PINW{1'b0}};
            s2 <= {`QQM_PINW{1'b0}};
            wclk_d <= 4'h0;
            rclk_d <= 4'h0;
        end
        else
        begin
            s1 <= {MASTER_RESET, PARTIAL_RESET, READ_QSEL, READ_CHIP_SELECT_N, READ_EN_N, READ_CLK,
                   WRITE_QSEL, DATA_IN, WRITE_CHIP_SELECT_N, WRITE_EN_N, WRITE_CLK};
            s2 <= s1;
            wclk_d <= wclk_s;
            rclk_d <= rclk_s;
        end
    end

    reg [8:0] cfg_reg;
    reg [8:0] cfg_act;
    reg [`QQM_CW-1:0] ae_ofs [0:3];
    reg [`QQM_CW-1:0] af_ofs [0:3];

    wire demux = cfg_act[`QQM_CFG_MODE] == `QQM_MODE_DEMUX;
    wire bcast = cfg_act[`QQM_CFG_MODE] == `QQM_MODE_BCAST;
    wire mux = !demux && !bcast;
    wire first_word_fall_through_mode = cfg_act[`QQM_CFG_FIRST_WORD_FALL_THROUGH_MODE];
    wire [1:0] ww = mux ? `QQM_W_X10 : cfg_act[`QQM_CFG_WW];
    wire [1:0] rw = mux ? cfg_act[`QQM_CFG_RW] : `QQM_W_X10;

    // edge beats: rising always, falling too under ddr
    wire [3:0] wrise = wclk_s & ~wclk_d;
    wire [3:0] wfall = ~wclk_s & wclk_d;
    wire [3:0] rrise = rclk_s & ~rclk_d;
    wire [3:0] rfall = ~rclk_s & rclk_d;
    wire [3:0] wedge = wrise | (cfg_act[`QQM_CFG_WDDR] ? wfall : 4'h0);
    wire [3:0] redge = rrise | (cfg_act[`QQM_CFG_RDDR] ? rfall : 4'h0);

    // write packers, one per port
    reg [`QQM_DW-1:0] wacc [0:3];
    reg [1:0] widx [0:3];
    reg [3:0] wc_v;
    reg [`QQM_DW-1:0] wc_d [0:3];
    reg [3:0] wbeat;
    reg [`QQM_DW-1:0] wword [0:3];
    integer p;

    always @*
    begin
        for (p = 0; p < 4; p = p + 1)
        begin
            // chip select and enable qualify the beat
            wbeat[p] = wedge[p] && !wen_n[p] && !wcs_n[p] && (mux || p == 0);
            // port p takes its own ten-bit lane; wide port is bus-matched
            // each edge word lands in the next slice of the internal word
            wword[p] = wacc[p] | ((((mux ? (din >> shamt(p[1:0], `QQM_W_X10)) : din) & unit_mask(ww)))
                       << shamt(widx[p], ww));
        end
    end

    always @(posedge REF_CLK or posedge RST)
    begin
        if (RST)
        begin
            wc_v <= 4'h0;
            for (p = 0; p < 4; p = p + 1)
            begin
                wacc[p] <= {`QQM_DW{1'b0}};
                widx[p] <= 2'h0;
                wc_d[p] <= {`QQM_DW{1'b0}};
            end
        end
        else
        begin
            wc_v <= 4'h0;
            for (p = 0; p < 4; p = p + 1)
            begin
                if (mrs)
                begin
                    wacc[p] <= {`QQM_DW{1'b0}};
                    widx[p] <= 2'h0;
                end
                else if (wbeat[p])
                begin
                    if (widx[p] == last_idx(ww))
                    begin
                        wc_v[p] <= 1'b1;
                        wc_d[p] <= wword[p];
                        wacc[p] <= {`QQM_DW{1'b0}};
                        widx[p] <= 2'h0;
                    end
                    else
                    begin
                        wacc[p] <= wword[p];
                        widx[p] <= widx[p] + 2'h1;
                    end
                end
            end
        end
    end

    // queue state
    reg [`QQM_AW-1:0] wptr [0:3];
    reg [`QQM_AW-1:0] rptr [0:3];
    reg [`QQM_CW-1:0] cnt [0:3];
    reg [3:0] hv;
    reg [3:0] pend;
    reg [1:0] ridx [0:3];
    reg [`QQM_DW-1:0] hd [0:3];
    wire [`QQM_DW-1:0] mem_rd [0:3];

    reg [3:0] full, empty, acc, pop, rbeat, pae, paf;
    reg [`QQM_DW-1:0] cur [0:3];
    integer q;

    always @*
    begin
        for (q = 0; q < 4; q = q + 1)
        begin
            full[q] = cnt[q] == `QQM_DEPTH;
            empty[q] = !hv[q] && cnt[q] == {`QQM_CW{1'b0}};
            pae[q] = cnt[q] <= ae_ofs[q];
            paf[q] = cnt[q] >= `QQM_DEPTH - af_ofs[q];
        end
        for (q = 0; q < 4; q = q + 1)
        begin
            // own port per queue; selected queue only; every queue
            // broadcast blocked by any full or partially resetting queue
            if (mux)
                acc[q] = wc_v[q] && !full[q] && !prs[q];
            else if (demux)
                acc[q] = wc_v[0] && wsel == q[1:0] && !full[q] && !prs[q];
            else
                acc[q] = wc_v[0] && full == 4'h0 && prs == 4'h0;
            // prefetch head only from a non-empty queue
            pop[q] = !hv[q] && !pend[q] && cnt[q] != {`QQM_CW{1'b0}} && !prs[q] && !mrs;
            // mux port reads only the queue on the select inputs; own port otherwise
            rbeat[q] = mux ? (redge[0] && !ren_n[0] && !rcs_n[0] && rsel == q[1:0])
                           : (redge[q] && !ren_n[q] && !rcs_n[q]);
            cur[q] = (hd[q] >> shamt(ridx[q], rw)) & unit_mask(rw);
        end
    end

    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1)
        begin : queue
            qqm_mem u_mem (
                .clk(REF_CLK),
                .we(acc[g]),
                .waddr(wptr[g]),
                .wdata(mux ? wc_d[g] : wc_d[0]),
                .re(pop[g]),
                .raddr(rptr[g]),
                .rdata(mem_rd[g])
            );
        end
    endgenerate

    always @(posedge REF_CLK or posedge RST)
    begin
        if (RST)
        begin
            hv <= 4'h0;
            pend <= 4'h0;
            for (q = 0; q < 4; q = q + 1)
            begin
                wptr[q] <= {`QQM_AW{1'b0}};
                rptr[q] <= {`QQM_AW{1'b0}};
                cnt[q] <= {`QQM_CW{1'b0}};
                ridx[q] <= 2'h0;
                hd[q] <= {`QQM_DW{1'b0}};
            end
        end
        else
        begin
            for (q = 0; q < 4; q = q + 1)
            begin
                // master reset clears every queue, partial reset only this queue's pointers; offsets and cfg untouched here
                if (mrs || prs[q])
                begin
                    wptr[q] <= {`QQM_AW{1'b0}};
                    rptr[q] <= {`QQM_AW{1'b0}};
                    cnt[q] <= {`QQM_CW{1'b0}};
                    hv[q] <= 1'b0;
                    pend[q] <= 1'b0;
                    ridx[q] <= 2'h0;
                end
                else
                begin
                    // pointers wrap naturally at the power-of-two depth
                    if (acc[q])
                        wptr[q] <= wptr[q] + 1'b1;
                    if (pop[q])
                        rptr[q] <= rptr[q] + 1'b1;
                    if (acc[q] && !pop[q])
                        cnt[q] <= cnt[q] + 1'b1;
                    else if (!acc[q] && pop[q])
                        cnt[q] <= cnt[q] - 1'b1;
                    pend[q] <= pop[q];
                    if (pend[q])
                    begin
                        hd[q] <= mem_rd[q];
                        hv[q] <= 1'b1;
                    end
                    else if (rbeat[q] && hv[q])
                    begin
                        if (ridx[q] == last_idx(rw))
                        begin
                            hv[q] <= 1'b0;
                            ridx[q] <= 2'h0;
                        end
                        else
                            ridx[q] <= ridx[q] + 2'h1;
                    end
                end
            end
        end
    end

    // read data, echoes and flags
    always @(posedge REF_CLK or posedge RST)
    begin
        if (RST)
        begin
            DATA_OUT <= {`QQM_DW{1'b0}};
            ECHO_READ_CLOCK <= 4'h0;
            ECHO_READ_ENABLE <= 4'h0;
            QUEUE_EMPTY_FLAG <= 4'h0;
            QUEUE_FULL_FLAG <= 4'h0;
            ALMOST_EMPTY <= 4'h0;
            ALMOST_FULL <= 4'h0;
            COMPOSITE_EMPTY_READY_FLAG <= 1'b0;
            COMPOSITE_FULL_READY_FLAG <= 1'b0;
        end
        else
        begin
            // echo clock follows the sampled read clock; only port 0 in mux mode
            ECHO_READ_CLOCK <= rclk_s & (mux ? `QQM_PORT0 : 4'hf);
            for (q = 0; q < 4; q = q + 1)
            begin
                // standard mode updates on a read; fall-through shows the head at once
                if ((first_word_fall_through_mode && hv[q] && (!mux || rsel == q[1:0])) || (!first_word_fall_through_mode && rbeat[q] && hv[q]))
                begin
                    if (mux)
                        DATA_OUT <= cur[q];
                    else
                        DATA_OUT[q*10 +: 10] <= cur[q][9:0];
                end
                // echo enable high while the last read beat placed a word
                if (rbeat[q])
                    ECHO_READ_ENABLE[mux ? 0 : q] <= hv[q];
            end
            // per-queue flags; fall-through gives output-ready and input-ready
            QUEUE_EMPTY_FLAG <= first_word_fall_through_mode ? hv : empty;
            QUEUE_FULL_FLAG <= first_word_fall_through_mode ? ~full : full;
            ALMOST_EMPTY <= pae;
            ALMOST_FULL <= paf;
            // composite empty follows the read-selected queue in mux, composite full the write-selected one in demux
            COMPOSITE_EMPTY_READY_FLAG <= mux && (first_word_fall_through_mode ? hv[rsel] : empty[rsel]);
            if (demux)
                COMPOSITE_FULL_READY_FLAG <= first_word_fall_through_mode ? !full[wsel] : full[wsel];
            // broadcast composite goes active on any full queue
            else if (bcast)
                COMPOSITE_FULL_READY_FLAG <= first_word_fall_through_mode ? full == 4'h0 : full != 4'h0;
            else
                COMPOSITE_FULL_READY_FLAG <= 1'b0;
        end
    end

    // apb slave, zero wait states
    wire setup = PSEL && !PENABLE;
    wire [7:0] ofs_off = PADDR - `QQM_REG_OFS0;
    wire [1:0] ofs_sel = ofs_off[3:2];
    wire ofs_hit = PADDR >= `QQM_REG_OFS0 && PADDR <= `QQM_REG_OFS3 && PADDR[1:0] == 2'h0;
    wire addr_hit = PADDR == `QQM_REG_CFG || PADDR == `QQM_REG_STAT || ofs_hit;
    reg [31:0] rd_mux;

    always @*
    begin
        rd_mux = 32'h0;
        if (PADDR == `QQM_REG_CFG)
            rd_mux = {23'h0, cfg_reg};
        else if (PADDR == `QQM_REG_STAT)
            rd_mux = {7'h00, cfg_act, paf, pae, full, empty};
        else if (ofs_hit)
            rd_mux = {2'h0, af_ofs[ofs_sel], 2'h0, ae_ofs[ofs_sel]};
    end

    always @(posedge REF_CLK or posedge RST)
    begin
        if (RST)
        begin
            PRDATA <= 32'h0;
            PREADY <= 1'b0;
            PSLVERR <= 1'b0;
            cfg_reg <= `QQM_CFG_RST;
            cfg_act <= `QQM_CFG_RST;
            for (q = 0; q < 4; q = q + 1)
            begin
                ae_ofs[q] <= `QQM_AE_RST;
                af_ofs[q] <= `QQM_AF_RST;
            end
        end
        else
        begin
            PREADY <= setup;
            PSLVERR <= setup && !addr_hit;
            PRDATA <= (setup && !PWRITE) ? rd_mux : 32'h0;
            if (PSEL && PENABLE && PREADY && PWRITE)
            begin
                // new settings wait in cfg_reg; the running mode never changes mid-stream
                if (PADDR == `QQM_REG_CFG)
                    cfg_reg <= PWDATA[`QQM_CFG_BITS];
                // offsets per queue, kept across partial reset
                else if (ofs_hit)
                begin
                    ae_ofs[ofs_sel] <= PWDATA[`QQM_OFS_AE];
                    af_ofs[ofs_sel] <= PWDATA[`QQM_OFS_AF];
                end
            end
            // configuration captured at master reset only
            if (mrs)
                cfg_act <= cfg_reg;
        end
    end
endmodule // qqm_top

/* sim/qqm_top_monitor.sv */
// port-level assertion checker for the four-queue buffer
`timescale 1ns/1ps

module qqm_top_monitor (
    input logic REF_CLK,
    input logic RST,
    input logic PSEL,
    input logic PENABLE,
    input logic [31:0] PRDATA,
    input logic PREADY,
    input logic PSLVERR,
    input logic [3:0] READ_CLK,
    input logic [3:0] READ_EN_N,
    input logic [3:0] READ_CHIP_SELECT_N,
    input logic [3:0] ECHO_READ_CLOCK,
    input logic [3:0] ECHO_READ_ENABLE,
    input logic [3:0] QUEUE_EMPTY_FLAG,
    input logic [3:0] QUEUE_FULL_FLAG,
    input logic [3:0] ALMOST_EMPTY,
    input logic [3:0] ALMOST_FULL,
    input logic COMPOSITE_EMPTY_READY_FLAG,
    input logic COMPOSITE_FULL_READY_FLAG
);
    default clocking mon_cb @(posedge REF_CLK);
    endclocking
    default disable iff (RST);

    a_ready_setup: assert property (PSEL && !PENABLE |=> PREADY)
        else $error("no ready in access cycle");
    a_ready_pulse: assert property (PREADY |=> !PREADY)
        else $error("ready held too long");
    a_err_answer: assert property (PSLVERR |-> PREADY && PRDATA == 32'h0)
        else $error("error without ready or with data");
    a_rdata_idle: assert property (!PREADY |-> PRDATA == 32'h0)
        else $error("read data outside access");
    a_comp_exclusive: assert property (!(COMPOSITE_EMPTY_READY_FLAG && COMPOSITE_FULL_READY_FLAG))
        else $error("both composite flags active");
    a_echo_rise: assert property ($rose(READ_CLK[0]) |-> ##[2:5] $rose(ECHO_READ_CLOCK[0]))
        else $error("echo clock missed rising edge");
    a_echo_fall: assert property ($fell(READ_CLK[0]) |-> ##[2:5] $fell(ECHO_READ_CLOCK[0]))
        else $error("echo clock missed falling edge");
    a_echo_cause: assert property ($rose(ECHO_READ_ENABLE[0]) |->
        $past(READ_EN_N[0], 4) == 1'b0 && $past(READ_CHIP_SELECT_N[0], 4) == 1'b0)
        else $error("echo enable without selected read");
    a_empty_almost: assert property ((QUEUE_EMPTY_FLAG & ~ALMOST_EMPTY) == 4'h0)
        else $error("empty queue not almost empty");
    a_full_almost: assert property ((QUEUE_FULL_FLAG & ~ALMOST_FULL) == 4'h0)
        else $error("full queue not almost full");
endmodule // qqm_top_monitor

/* sim/qqm_link_model.sv */
// far-side writer and reader logic driving the port pins
`timescale 1ns/1ps

module qqm_link_model (
    input logic clk,
    output logic [3:0] wr_clk,
    output logic [3:0] wr_en_n,
    output logic [3:0] wr_cs_n,
    output logic [39:0] data,
    output logic [3:0] rd_clk,
    output logic [3:0] rd_en_n,
    output logic [3:0] rd_cs_n
);
    initial
    begin
        wr_clk <= 4'h0;
        wr_en_n <= 4'hf;
        wr_cs_n <= 4'hf;
        data <= 40'h0;
        rd_clk <= 4'h0;
        rd_en_n <= 4'hf;
        rd_cs_n <= 4'hf;
    end

    // single-rate write beat, 160 ns link period; clock idles low between beats
    // enables drop while the clock is still high so back-to-back beats never touch one signal twice
    task automatic wr(input logic [1:0] p, input logic [39:0] d, input logic cs_n);
        @(posedge clk);
        data <= d;
        wr_en_n[p] <= 1'b0;
        wr_cs_n[p] <= cs_n;
        repeat (16) @(posedge clk);
        wr_clk[p] <= 1'b1;
        repeat (8) @(posedge clk);
        wr_en_n[p] <= 1'b1;
        wr_cs_n[p] <= 1'b1;
        // released bus shows the inverse so stale data never looks valid
        data <= ~d;
        repeat (7) @(posedge clk);
        wr_clk[p] <= 1'b0;
    endtask

    task automatic rd(input logic [1:0] p);
        @(posedge clk);
        rd_en_n[p] <= 1'b0;
        rd_cs_n[p] <= 1'b0;
        repeat (16) @(posedge clk);
        rd_clk[p] <= 1'b1;
        repeat (8) @(posedge clk);
        rd_en_n[p] <= 1'b1;
        rd_cs_n[p] <= 1'b1;
        repeat (7) @(posedge clk);
        rd_clk[p] <= 1'b0;
    endtask
endmodule // qqm_link_model

/* sim/testbench.sv */
// self-checking bench for the four-queue buffer
`timescale 1ns/1ps
`include "qqm_consts.vh"

module testbench;
    logic REF_CLK = 0, RST = 1, PSEL = 0, PENABLE = 0, PWRITE = 0, MASTER_RESET = 0;
    logic [7:0] PADDR = 0;
    logic [31:0] PWDATA = 0, PRDATA;
    logic PREADY, PSLVERR, COMPOSITE_EMPTY_READY_FLAG, COMPOSITE_FULL_READY_FLAG;
    logic [3:0] WRITE_CLK, WRITE_EN_N, WRITE_CHIP_SELECT_N, READ_CLK, READ_EN_N, READ_CHIP_SELECT_N;
    logic [3:0] PARTIAL_RESET = 0, ECHO_READ_CLOCK, ECHO_READ_ENABLE, QUEUE_EMPTY_FLAG, QUEUE_FULL_FLAG;
    logic [3:0] ALMOST_EMPTY, ALMOST_FULL, ren;
    logic [1:0] WRITE_QSEL = 0, READ_QSEL = 0;
    logic [39:0] DATA_IN, DATA_OUT, msk = 40'h3ff, w, u;
    logic [39:0] ws[4];
    logic mux = 1;
    integer seed = 32'h61fd, errors = 0, n_compared = 0, nb;
    logic [40:0] apq[$], dq[$];
    localparam logic [40:0] SLV = 41'h100000000;

    qqm_top dut_u (.*);
    qqm_link_model link_u (.clk(REF_CLK), .wr_clk(WRITE_CLK), .wr_en_n(WRITE_EN_N), .wr_cs_n(WRITE_CHIP_SELECT_N),
        .data(DATA_IN), .rd_clk(READ_CLK), .rd_en_n(READ_EN_N), .rd_cs_n(READ_CHIP_SELECT_N));

    always #2.5 REF_CLK = ~REF_CLK;

    task automatic chk(input logic [40:0] seen, input logic [40:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            errors++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [40:0] e);
        @(posedge REF_CLK);
        PSEL <= 1'b1;
        PENABLE <= 1'b0;
        PWRITE <= wr;
        PADDR <= a;
        PWDATA <= d;
        apq.push_back(e);
        @(posedge REF_CLK);
        PENABLE <= 1'b1;
        do @(posedge REF_CLK); while (PREADY !== 1'b1);
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask

    task automatic read_beat(input logic [1:0] p, input logic [40:0] e);
        dq.push_back(e);
        link_u.rd(p);
    endtask

    // setup held steady across master reset
    task automatic mreset(input logic [31:0] cfg);
        apb(1'b1, 8'h00, cfg, 41'h0);
        apb(1'b0, 8'h00, 32'h0, {9'h0, cfg});
        @(posedge REF_CLK) MASTER_RESET <= 1'b1;
        repeat (32) @(posedge REF_CLK);
        MASTER_RESET <= 1'b0;
        repeat (8) @(posedge REF_CLK);
        mux = (cfg[1:0] == 2'h0);
    endtask

    task automatic stop_test;
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    always @(negedge REF_CLK)
        if (PSEL && PENABLE && PREADY === 1'b1)
            chk({8'h0, PSLVERR, PRDATA}, apq.pop_front());

    // selected ports noted at the read clock's rise, answer taken once the read clock falls
    always @(posedge READ_CLK[0] or posedge READ_CLK[1] or posedge READ_CLK[2] or posedge READ_CLK[3])
    begin
        ren = ~(READ_EN_N | READ_CHIP_SELECT_N);
        @(negedge READ_CLK[0] or negedge READ_CLK[1] or negedge READ_CLK[2] or negedge READ_CLK[3]);
        for (int p = 0; p < 4; p++)
            if (ren[p])
                chk({ECHO_READ_ENABLE[p], (DATA_OUT >> (mux ? 0 : 10 * p)) & msk}, dq.pop_front());
    end

    // whole run needs about 21 us
    initial
    begin
        #200000;
        errors++;
        stop_test();
    end

    initial
    begin
        repeat (4) @(posedge REF_CLK);
        RST <= 1'b0;
        repeat (4) @(posedge REF_CLK);
        apb(1'b0, 8'h00, 32'h0, 41'h0);
        apb(1'b0, 8'h04, 32'h0, 41'h00000f0f);
        apb(1'b0, 8'h08, 32'h0, 41'h00100010);
        apb(1'b1, 8'h04, 32'hffffffff, 41'h0);
        apb(1'b0, 8'h04, 32'h0, 41'h00000f0f);
        apb(1'b1, 8'h18, 32'h1, SLV);
        apb(1'b0, 8'h18, 32'h0, SLV);
        // almost-empty offset kept at 16 or more so the almost flags stay set
        w = 40'(($random(seed) & 32'h0fff3fff) | 32'h00100010);
        apb(1'b1, 8'h10, w[31:0], 41'h0);
        apb(1'b0, 8'h10, 32'h0, {9'h0, w[31:0]});
        apb(1'b0, 8'h14, 32'h0, 41'h00100010);
        $display("register test done");
        for (int rw = 0; rw < 3; rw++)
        begin
            mreset(32'(rw << 6));
            msk = (rw == 0) ? `QQM_MASK_X10 : (rw == 1) ? `QQM_MASK_X20 : `QQM_MASK_X40;
            nb = 4 >> rw;
            for (int q = 0; q < 4; q++)
            begin
                ws[q] = 40'h0;
                for (int k = 0; k < 4; k++)
                begin
                    u = 40'($random(seed)) & 40'h3ff;
                    ws[q] = ws[q] | (u << (10 * k));
                    link_u.wr(q[1:0], u << (10 * q), 1'b0);
                    if (k == 1)
                        link_u.wr(q[1:0], ~(u << (10 * q)), 1'b1);
                end
            end
            for (int q = 0; q < 4; q++)
            begin
                @(posedge REF_CLK) READ_QSEL <= q[1:0];
                for (int k = 0; k < nb; k++)
                    read_beat(2'h0, {1'b1, (ws[q] >> (k * (10 << rw))) & msk});
            end
            read_beat(2'h0, {1'b0, (ws[3] >> ((nb - 1) * (10 << rw))) & msk});
            @(negedge REF_CLK);
            chk({36'h0, QUEUE_EMPTY_FLAG, COMPOSITE_EMPTY_READY_FLAG}, 41'h1f);
            $display("mux test done");
        end
        mreset(32'h21);
        msk = `QQM_MASK_X10;
        for (int q = 0; q < 4; q++)
        begin
            @(posedge REF_CLK) WRITE_QSEL <= q[1:0];
            ws[q] = 40'({$random(seed), $random(seed)});
            link_u.wr(2'h0, ws[q], 1'b0);
        end
        for (int q = 0; q < 4; q++)
            for (int k = 0; k < 4; k++)
                read_beat(q[1:0], {1'b1, (ws[q] >> (10 * k)) & msk});
        $display("demux test done");
        mreset(32'h22);
        w = 40'({$random(seed), $random(seed)});
        link_u.wr(2'h0, w, 1'b0);
        @(posedge REF_CLK) PARTIAL_RESET <= 4'h2;
        link_u.wr(2'h0, ~w, 1'b0);
        @(posedge REF_CLK) PARTIAL_RESET <= 4'h0;
        apb(1'b0, 8'h04, 32'h0, 41'h00220f02);
        @(negedge REF_CLK);
        chk({23'h0, QUEUE_FULL_FLAG, ALMOST_FULL, ALMOST_EMPTY, QUEUE_EMPTY_FLAG, COMPOSITE_EMPTY_READY_FLAG,
             COMPOSITE_FULL_READY_FLAG}, 41'h3c8);
        for (int q = 0; q < 4; q += 3)
        begin
            for (int k = 0; k < 4; k++)
                read_beat(q[1:0], {1'b1, (w >> (10 * k)) & msk});
            read_beat(q[1:0], {1'b0, (w >> 30) & msk});
        end
        $display("broadcast test done");
        stop_test();
    end
endmodule // testbench

bind qqm_top qqm_top_monitor mon_u (.*);
